//--- hw/dacr_pkg.sv
// Constants and types shared by the converter channel and range control files
package dacr_pkg;
  // Clock and reset timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned FULL_RESET_NS  = 1200;
  localparam int unsigned FULL_RESET_CYC = (FULL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths and depths
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned RES_W       = 16;
  localparam int unsigned CH_PER_SIDE = 8;
  localparam int unsigned SEQ_DEPTH   = 8;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam int unsigned PIN_W       = 9;

  // Register offsets
  localparam logic [3:0] REG_CONFIG   = 4'h0;
  localparam logic [3:0] REG_CHANNEL  = 4'h1;
  localparam logic [3:0] REG_RANGE_A  = 4'h2;
  localparam logic [3:0] REG_RANGE_B  = 4'h3;
  localparam logic [3:0] REG_SEQ_BASE = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'hc;

  // Field positions
  localparam int unsigned CFG_SEQ_EN_BIT   = 0;
  localparam int unsigned CFG_SEQ_LAST_LSB = 1;
  localparam int unsigned FRM_WR_BIT       = 23;
  localparam int unsigned FRM_ADDR_LSB     = 16;

  // Reset values
  localparam logic [15:0] CONFIG_RST  = 16'h0000;
  localparam logic [15:0] CHANNEL_RST = 16'h0000;
  localparam logic [15:0] RANGE_RST   = 16'hffff;
  localparam logic [7:0]  SEQ_RST     = 8'h00;

  // Serial frame
  localparam logic [4:0] FRAME_LAST = 5'h17;

  // Channel code of the supply monitor
  localparam logic [3:0] DIAG_SEL = 4'h8;

  typedef enum logic [1:0]
  {
    DACR_RANGE_SW  = 2'b00,
    DACR_RANGE_2V5 = 2'b01,
    DACR_RANGE_5V  = 2'b10,
    DACR_RANGE_10V = 2'b11
  } dacr_range_e;

  localparam dacr_range_e DIAG_RANGE = DACR_RANGE_10V;

  typedef enum logic [2:0]
  {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_DONE  = 3'b100
  } dacr_ser_e;

  typedef struct packed
  {
    logic [15:0] a;
    logic [15:0] b;
  } dacr_pair_s;

  typedef struct packed
  {
    logic [3:0]  sel_a;
    logic [3:0]  sel_b;
    dacr_range_e range_a;
    dacr_range_e range_b;
  } dacr_conv_s;

  localparam dacr_conv_s CONV_RST = '{sel_a: 4'h0, sel_b: 4'h0,
                                      range_a: DACR_RANGE_10V, range_b: DACR_RANGE_10V};
endpackage

//--- hw/dacr_pair_buf.sv
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module dacr_pair_buf #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW:0]      cnt;
  logic [PW:0]      next_cnt;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign next_cnt = cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  assign out_data = mem[rp];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      cnt       <= next_cnt;
      in_ready  <= (next_cnt != (PW + 1)'(DEPTH));
      out_valid <= (next_cnt != '0);
    end
  end
endmodule

//--- hw/dacr_ctrl.sv
// Channel, range and serial control of the dual simultaneous sampling converter
`timescale 1ns/1ps
// Notes on behaviour
// - Range-select pin pair chooses hardware or software configuration mode.
// - Hardware mode configures only from the dedicated pins.
// - Software mode configures from registers written over serial or parallel access.
// - Two converters sample together, eight inputs each, sixteen in all.
// - Supply monitor channel is selectable only in software mode.
// - Channels come from pick pins in hardware mode, channel register in software.
// - Hardware mode always pairs side A channel n with side B channel n.
// - Software mode pairs any side A channel with any side B channel.
// - Pins 00 software, 01 2.5 V, 10 5 V, 11 10 V for all.
// - Software mode gives each input channel its own programmed range; the supply monitor stays at 10 V.
// - Channels chosen per conversion or stepped from a preset sequencer list.
// - Serial output bits launch after a rising serial clock edge.
// - Serial input bits are captured on a falling serial clock edge.
// - Serial outputs float once chip select goes high.
// - Results are sixteen-bit two's complement words.
// - Reset held low over 1.2 us shuts down and restores all registers.
module dacr_ctrl (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic [1:0]                   range_mode_pins,
  input  wire logic [2:0]                   channel_pick_pins,
  input  wire logic                         convst,
  input  wire logic                         sclk,
  input  wire logic                         cs_b,
  input  wire logic                         sdi,
  input  wire logic [dacr_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [dacr_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [dacr_pkg::DATA_W-1:0]  reg_rdata,
  input  wire dacr_pkg::dacr_pair_s         res_data,
  input  wire logic                         res_valid,
  output logic                              res_ready,
  output logic      [1:0]                   serial_out_lanes,
  output logic                              serial_out_oe,
  output logic                              conv_go,
  output dacr_pkg::dacr_conv_s              conv_cmd,
  output logic                              sw_mode,
  output logic                              shutdown
);
  // Pin synchronisers, third stage only for edge detection
  logic [dacr_pkg::PIN_W-1:0] pin_raw;
  logic [dacr_pkg::PIN_W-1:0] pin_s1;
  logic [dacr_pkg::PIN_W-1:0] pin_s2;
  logic [dacr_pkg::PIN_W-1:0] pin_s3;

  assign pin_raw = {range_mode_pins, channel_pick_pins, convst, sclk, cs_b, sdi};

  always_ff @(posedge clk)
  begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  logic [1:0] rng_pins;
  logic [2:0] pick_pins;
  logic       convst_rise;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_low;
  logic       cs_fall;
  logic       sdi_s;

  assign rng_pins    = pin_s2[8:7];
  assign pick_pins   = pin_s2[6:4];
  assign convst_rise = pin_s2[3] & ~pin_s3[3];
  assign sclk_rise   = pin_s2[2] & ~pin_s3[2];
  assign sclk_fall   = ~pin_s2[2] & pin_s3[2];
  assign cs_low      = ~pin_s2[1];
  assign cs_fall     = ~pin_s2[1] & pin_s3[1];
  assign sdi_s       = pin_s2[0];

  // Full reset after a long low reset, history needs no reset of its own
  logic [dacr_pkg::FULL_RESET_CYC-1:0] rst_hist;
  logic                                full_rst;

  always_ff @(posedge clk)
  begin
    rst_hist <= {rst_hist[dacr_pkg::FULL_RESET_CYC-2:0], rst_b};
  end

  assign full_rst = ~rst_b & ~|rst_hist;

  // Mode decode
  logic sw_mode_w;

  assign sw_mode_w = (rng_pins == dacr_pkg::DACR_RANGE_SW);

  // Configuration registers
  logic [15:0]                    cfg;
  logic [15:0]                    chan;
  logic [15:0]                    rng_a;
  logic [15:0]                    rng_b;
  logic [dacr_pkg::SEQ_DEPTH-1:0][7:0] seq_mem;
  logic                           ser_wr;
  logic [3:0]                     ser_addr;
  logic [15:0]                    ser_data;
  logic                           any_wr;
  logic [3:0]                     wr_addr;
  logic [15:0]                    wr_data;
  logic [dacr_pkg::SEQ_DEPTH-1:0] seq_hit;

  // Parallel write wins when both paths write in one cycle
  assign any_wr  = reg_wr | ser_wr;
  assign wr_addr = reg_wr ? reg_addr : ser_addr;
  assign wr_data = reg_wr ? reg_wdata : ser_data;

  for (genvar i = 0; i < dacr_pkg::SEQ_DEPTH; i++)
  begin : g_seq
    assign seq_hit[i] = any_wr && (wr_addr == dacr_pkg::REG_SEQ_BASE + 4'(i));
  end

  always_ff @(posedge clk)
  begin
    if (full_rst)
    begin
      cfg     <= dacr_pkg::CONFIG_RST;
      chan    <= dacr_pkg::CHANNEL_RST;
      rng_a   <= dacr_pkg::RANGE_RST;
      rng_b   <= dacr_pkg::RANGE_RST;
      seq_mem <= {dacr_pkg::SEQ_DEPTH{dacr_pkg::SEQ_RST}};
    end
    else if (any_wr)
    begin
      if (wr_addr == dacr_pkg::REG_CONFIG)
        cfg <= wr_data;
      if (wr_addr == dacr_pkg::REG_CHANNEL)
        chan <= wr_data;
      if (wr_addr == dacr_pkg::REG_RANGE_A)
        rng_a <= wr_data;
      if (wr_addr == dacr_pkg::REG_RANGE_B)
        rng_b <= wr_data;
      for (int k = 0; k < dacr_pkg::SEQ_DEPTH; k++)
        if (seq_hit[k])
          seq_mem[k] <= wr_data[7:0];
    end
  end

  // Sequencer position and buffer state for readback
  logic [2:0] seq_idx;
  logic [2:0] seq_last;
  logic       seq_en;
  logic       buf_valid;

  assign seq_en   = cfg[dacr_pkg::CFG_SEQ_EN_BIT];
  assign seq_last = cfg[dacr_pkg::CFG_SEQ_LAST_LSB +: 3];

  function automatic logic [15:0] rd_word(input logic [3:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    case (addr)
      dacr_pkg::REG_CONFIG:  w = cfg;
      dacr_pkg::REG_CHANNEL: w = chan;
      dacr_pkg::REG_RANGE_A: w = rng_a;
      dacr_pkg::REG_RANGE_B: w = rng_b;
      dacr_pkg::REG_STATUS:  w = {9'h000, buf_valid, seq_idx, rng_pins, sw_mode_w};
      default:
        if (addr >= dacr_pkg::REG_SEQ_BASE && addr < dacr_pkg::REG_STATUS)
          w = {8'h00, seq_mem[3'(addr - dacr_pkg::REG_SEQ_BASE)]};
    endcase
    return w;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_word(reg_addr) : 16'h0000;
  end

  // Channel and range selection
  function automatic dacr_pkg::dacr_range_e sw_range(input logic [15:0] field,
                                                     input logic [3:0]  sel);
    logic [1:0] code;
    code = field[{sel[2:0], 1'b0} +: 2];
    if (sel[3])
      return dacr_pkg::DIAG_RANGE;
    else if (code == 2'b00)
      return dacr_pkg::DACR_RANGE_10V;
    else
      return dacr_pkg::dacr_range_e'(code);
  endfunction

  logic [7:0]           sw_entry;
  logic [3:0]           sw_a;
  logic [3:0]           sw_b;
  dacr_pkg::dacr_conv_s sw_cmd;
  dacr_pkg::dacr_conv_s hw_cmd;
  dacr_pkg::dacr_conv_s next_cmd;

  assign sw_entry = seq_en ? seq_mem[seq_idx] : chan[7:0];
  assign sw_a     = sw_entry[3] ? dacr_pkg::DIAG_SEL : sw_entry[3:0];
  assign sw_b     = sw_entry[7] ? dacr_pkg::DIAG_SEL : sw_entry[7:4];
  assign sw_cmd   = dacr_pkg::dacr_conv_s'{sel_a: sw_a, sel_b: sw_b,
                                           range_a: sw_range(rng_a, sw_a),
                                           range_b: sw_range(rng_b, sw_b)};
  assign hw_cmd   = dacr_pkg::dacr_conv_s'{sel_a: {1'b0, pick_pins},
                                           sel_b: {1'b0, pick_pins},
                                           range_a: dacr_pkg::dacr_range_e'(rng_pins),
                                           range_b: dacr_pkg::dacr_range_e'(rng_pins)};
  assign next_cmd = sw_mode_w ? sw_cmd : hw_cmd;

  // One request drives both converters together
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      conv_go  <= 1'b0;
      conv_cmd <= dacr_pkg::CONV_RST;
      seq_idx  <= 3'h0;
      sw_mode  <= 1'b0;
      shutdown <= 1'b0;
    end
    else
    begin
      conv_go  <= convst_rise;
      sw_mode  <= sw_mode_w;
      shutdown <= 1'b0;
      if (convst_rise)
        conv_cmd <= next_cmd;
      if (!seq_en || !sw_mode_w)
        seq_idx <= 3'h0;
      else if (convst_rise)
        seq_idx <= (seq_idx == seq_last) ? 3'h0 : seq_idx + 3'h1;
    end
    if (full_rst)
      shutdown <= 1'b1;
  end

  // Result buffer between converter core and serial shifter
  logic [31:0]          buf_raw;
  dacr_pkg::dacr_pair_s buf_out;
  logic                 buf_pop;

  assign buf_out = dacr_pkg::dacr_pair_s'(buf_raw);

  dacr_pair_buf #(
    .WIDTH ($bits(dacr_pkg::dacr_pair_s)),
    .DEPTH (dacr_pkg::BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (res_valid),
    .in_data   (res_data),
    .in_ready  (res_ready),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_raw)
  );

  // Serial frame engine
  dacr_pkg::dacr_ser_e ser_state;
  logic [4:0]          bit_cnt;
  logic [23:0]         rx_sh;
  logic [23:0]         rx_next;
  logic [15:0]         tx_a;
  logic [15:0]         tx_b;
  logic                rd_pend;
  logic [3:0]          rd_addr;
  logic                frame_start;
  logic [15:0]         load_a;
  logic [15:0]         load_b;

  assign frame_start = (ser_state == dacr_pkg::SER_IDLE) && cs_fall;
  assign buf_pop     = frame_start & ~rd_pend & buf_valid;
  assign rx_next     = {rx_sh[22:0], sdi_s};
  always_comb load_a = rd_pend ? rd_word(rd_addr) : (buf_valid ? buf_out.a : 16'h0000);
  assign load_b      = (!rd_pend && buf_valid) ? buf_out.b : 16'h0000;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ser_state <= dacr_pkg::SER_IDLE;
      bit_cnt   <= 5'h00;
      rx_sh     <= 24'h000000;
      tx_a      <= 16'h0000;
      tx_b      <= 16'h0000;
      rd_pend   <= 1'b0;
      rd_addr   <= 4'h0;
      ser_wr    <= 1'b0;
      ser_addr  <= 4'h0;
      ser_data  <= 16'h0000;
    end
    else
    begin
      ser_wr <= 1'b0;
      case (ser_state)
        dacr_pkg::SER_IDLE:
          if (cs_fall)
          begin
            ser_state <= dacr_pkg::SER_SHIFT;
            bit_cnt   <= 5'h00;
            tx_a      <= load_a;
            tx_b      <= load_b;
            rd_pend   <= 1'b0;
          end
        dacr_pkg::SER_SHIFT:
          if (!cs_low)
            ser_state <= dacr_pkg::SER_IDLE;
          else
          begin
            if (sclk_rise)
            begin
              tx_a <= {tx_a[14:0], 1'b0};
              tx_b <= {tx_b[14:0], 1'b0};
            end
            if (sclk_fall)
            begin
              rx_sh   <= rx_next;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == dacr_pkg::FRAME_LAST)
              begin
                ser_state <= dacr_pkg::SER_DONE;
                ser_wr    <= rx_next[dacr_pkg::FRM_WR_BIT];
                ser_addr  <= rx_next[dacr_pkg::FRM_ADDR_LSB +: 4];
                ser_data  <= rx_next[15:0];
                rd_pend   <= ~rx_next[dacr_pkg::FRM_WR_BIT];
                rd_addr   <= rx_next[dacr_pkg::FRM_ADDR_LSB +: 4];
              end
            end
          end
        dacr_pkg::SER_DONE:
          if (!cs_low)
            ser_state <= dacr_pkg::SER_IDLE;
        default:
          ser_state <= dacr_pkg::SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      serial_out_lanes <= 2'b00;
      serial_out_oe    <= 1'b0;
    end
    else
    begin
      serial_out_lanes <= {tx_b[15], tx_a[15]};
      serial_out_oe    <= cs_low && (ser_state != dacr_pkg::SER_IDLE);
    end
  end
endmodule

//--- verif/dacr_ctrl_monitor.sv
// Port-level assertion checker for the channel and range control block
`timescale 1ns/1ps
module dacr_ctrl_monitor (
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic [1:0]                  range_mode_pins,
  input wire logic [2:0]                  channel_pick_pins,
  input wire logic                        convst,
  input wire logic                        sclk,
  input wire logic                        cs_b,
  input wire logic                        sdi,
  input wire logic [dacr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dacr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [dacr_pkg::DATA_W-1:0] reg_rdata,
  input wire dacr_pkg::dacr_pair_s        res_data,
  input wire logic                        res_valid,
  input wire logic                        res_ready,
  input wire logic [1:0]                  serial_out_lanes,
  input wire logic                        serial_out_oe,
  input wire logic                        conv_go,
  input wire dacr_pkg::dacr_conv_s        conv_cmd,
  input wire logic                        sw_mode,
  input wire logic                        shutdown
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_go_edge: assert property ($rose(convst) |-> ##[2:6] conv_go)
    else $error("conv_go missing after convst rise");
  a_go_pulse: assert property (conv_go |->
    ($past(convst, 3) && !$past(convst, 4)) ##1 !conv_go)
    else $error("conv_go not a single caused pulse");
  a_hw_pair: assert property (conv_go && !sw_mode |->
    conv_cmd.sel_a == conv_cmd.sel_b &&
    conv_cmd.sel_a == {1'b0, $past(channel_pick_pins, 3)})
    else $error("hardware mode channel pair wrong");
  a_hw_range: assert property (conv_go && !sw_mode |->
    conv_cmd.range_a == $past(range_mode_pins, 3) &&
    conv_cmd.range_b == $past(range_mode_pins, 3))
    else $error("hardware mode range differs from pins");
  a_oe_idle: assert property (cs_b [*8] |-> !serial_out_oe)
    else $error("serial lanes driven with chip select high");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer cycle");
  a_shut_exit: assert property (rst_b && $past(rst_b) |-> !shutdown)
    else $error("shutdown held after reset release");
  a_sw_on: assert property ((range_mode_pins == 2'h0) [*4] |=> sw_mode)
    else $error("software mode not entered");
  a_sw_off: assert property ((range_mode_pins != 2'h0) [*4] |=> !sw_mode)
    else $error("hardware mode not entered");
endmodule

bind dacr_ctrl dacr_ctrl_monitor mon_u (.clk, .rst_b, .range_mode_pins, .channel_pick_pins,
  .convst, .sclk, .cs_b, .sdi, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .res_data,
  .res_valid, .res_ready, .serial_out_lanes, .serial_out_oe, .conv_go, .conv_cmd, .sw_mode,
  .shutdown);

//--- verif/dacr_host_model.sv
// Host serial controller model driving frames at a 125 ns serial clock
`timescale 1ns/1ps
module dacr_host_model (
  output logic            sclk,
  output logic            cs_b,
  output logic            sdi,
  input  wire logic [1:0] lanes
);
  initial
  begin
    sclk = 1'b1;
    cs_b = 1'b1;
    sdi  = 1'b1;
  end

  // Clock stands high between frames; sdi goes to the inverse once released
  task automatic frame(input logic [23:0] cmd, output logic [15:0] a, output logic [15:0] b);
    a = 16'h0000;
    b = 16'h0000;
    #3.3 cs_b = 1'b0;
    #100;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = cmd[i];
      #62.5 sclk = 1'b0;
      if (i > 7)
      begin
        a = {a[14:0], lanes[0]};
        b = {b[14:0], lanes[1]};
      end
      #62.5 sclk = 1'b1;
    end
    #62.5 cs_b = 1'b1;
    sdi = ~sdi;
    #100;
  endtask
endmodule

//--- verif/dacr_ctrl_tb_top.sv
// Self-checking testbench of the channel and range control block
`timescale 1ns/1ps
module dacr_ctrl_tb_top;
  logic                 clk;
  logic                 rst_b;
  logic [1:0]           range_mode_pins;
  logic [2:0]           channel_pick_pins;
  logic                 convst;
  logic                 sclk;
  logic                 cs_b;
  logic                 sdi;
  logic [3:0]           reg_addr;
  logic [15:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [15:0]          reg_rdata;
  dacr_pkg::dacr_pair_s res_data;
  logic                 res_valid;
  logic                 res_ready;
  logic [1:0]           serial_out_lanes;
  logic                 serial_out_oe;
  logic                 conv_go;
  dacr_pkg::dacr_conv_s conv_cmd;
  logic                 sw_mode;
  logic                 shutdown;
  logic [15:0]          a;
  logic [15:0]          b;
  int                   mismatches;
  int                   compares;
  int                   cycles;
  logic [16:0]          rows [4];
  logic [31:0]          ex [3];
  localparam int        SETTLE_CYC = 12000;

  dacr_ctrl dut_u (.clk, .rst_b, .range_mode_pins, .channel_pick_pins, .convst, .sclk, .cs_b,
    .sdi, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .res_data, .res_valid,
    .res_ready, .serial_out_lanes, .serial_out_oe, .conv_go, .conv_cmd, .sw_mode, .shutdown);
  dacr_host_model host_u (.sclk, .cs_b, .sdi, .lanes(serial_out_lanes));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] ad, input logic [15:0] e);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
    @(posedge clk);
  endtask

  task automatic conv(input logic [11:0] e);
    int n;
    n = 0;
    convst <= 1'b1;
    @(posedge clk);
    #1;
    while (conv_go !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("conv_go", 1, conv_go);
    chk("conv_cmd", e, conv_cmd);
    @(posedge clk);
    convst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    rows = '{{2'h1, 3'h0, 12'h005}, {2'h2, 3'h7, 12'h77a}, {2'h3, 3'h3, 12'h33f},
             {2'h1, 3'h5, 12'h555}};
    ex = '{32'h80017fff, 32'h1234fedc, 32'h00000000};
    {mismatches, compares, cycles} = '0;
    rst_b = 1'b0;
    range_mode_pins = 2'h1;
    channel_pick_pins = 3'h0;
    {convst, reg_wr, reg_rd, res_valid} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    res_data = 32'h00000000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      range_mode_pins <= rows[i][16:15];
      channel_pick_pins <= rows[i][14:12];
      repeat (SETTLE_CYC) @(posedge clk);
      chk("sw_mode", 0, sw_mode);
      conv(rows[i][11:0]);
    end
    rst_b <= 1'b0;
    repeat (125) @(posedge clk);
    #1;
    chk("shutdown", 1, shutdown);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk("shutdown", 0, shutdown);
    @(posedge clk);
    rd(dacr_pkg::REG_CONFIG, dacr_pkg::CONFIG_RST);
    rd(dacr_pkg::REG_CHANNEL, dacr_pkg::CHANNEL_RST);
    rd(dacr_pkg::REG_RANGE_A, dacr_pkg::RANGE_RST);
    rd(dacr_pkg::REG_RANGE_B, dacr_pkg::RANGE_RST);
    rd(dacr_pkg::REG_SEQ_BASE, {8'h00, dacr_pkg::SEQ_RST});
    wr(4'hd, 16'h1234);
    rd(4'hd, 16'h0000);
    range_mode_pins <= 2'h0;
    repeat (6) @(posedge clk);
    chk("sw_mode", 1, sw_mode);
    wr(dacr_pkg::REG_CHANNEL, 16'h0083);
    wr(dacr_pkg::REG_RANGE_A, 16'hff7f);
    conv(12'h387);
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    conv(12'h387);
    wr(dacr_pkg::REG_RANGE_B, 16'hfff3);
    wr(4'h4, 16'h0010);
    wr(4'h5, 16'h0025);
    wr(dacr_pkg::REG_CONFIG, 16'h0003);
    conv(12'h01f);
    conv(12'h52f);
    conv(12'h01f);
    wr(dacr_pkg::REG_CONFIG, 16'h0000);
    rd(dacr_pkg::REG_STATUS, 16'h0001);
    host_u.frame(24'h810042, a, b);
    @(posedge clk);
    rd(dacr_pkg::REG_CHANNEL, 16'h0042);
    host_u.frame(24'h010000, a, b);
    host_u.frame(24'h8d0000, a, b);
    chk("lanes", 32'h00420000, {a, b});
    @(posedge clk);
    res_data <= 32'h80017fff;
    res_valid <= 1'b1;
    @(posedge clk);
    res_data <= 32'h1234fedc;
    @(posedge clk);
    res_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk("res_ready", 0, res_ready);
    foreach (ex[i])
    begin
      host_u.frame(24'h8d0000, a, b);
      chk("lanes", ex[i], {a, b});
    end
    @(posedge clk);
    #1;
    chk("res_ready", 1, res_ready);
    summarize();
  end
endmodule
